// >>> tb_turret_tool_change_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_turret_tool_change_sequencer;
	localparam int unsigned TICKS = 4;
	logic ref_clk, srst, clamp_sense_enable, change_req, clamp_in_position, busy, change_done;
	logic general_out_eleven, general_out_twelve, turret_cw_drive, turret_ccw_drive;
	logic change_skipped, alarm_search_timeout, alarm_lock_timeout, alarm_pos_mismatch;
	logic alarm_bad_mode, blind, clamp_ok, clk_en;
	logic [3:0] mode;
	logic [15:0] search_lim, t1, lock_t, t2;
	logic [2:0] target_tool, current_tool;
	logic [7:0] pos_in;
	logic [31:0] rng = 32'h0000AD51;
	int fail_count = 0;
	int n_compared = 0;
	int exp_tool = 0;

	tts_sequencer #(.TICK_CYCLES(TICKS)) dut (
		.ref_clk, .srst, .clk_en, .tool_change_mode_select(mode),
		.index_search_time_limit(search_lim), .cw_to_ccw_delay(t1), .clamp_lock_time(lock_t),
		.post_clamp_delay(t2), .clamp_sense_enable, .change_req, .target_tool,
		.tool_pos_in_1(pos_in[0]), .tool_pos_in_2(pos_in[1]), .tool_pos_in_3(pos_in[2]),
		.tool_pos_in_4(pos_in[3]), .tool_pos_in_5(pos_in[4]), .tool_pos_in_6(pos_in[5]),
		.tool_pos_in_7(pos_in[6]), .tool_pos_in_8(pos_in[7]), .clamp_in_position,
		.general_out_eleven, .general_out_twelve, .turret_cw_drive, .turret_ccw_drive,
		.current_tool, .busy, .change_done, .change_skipped, .alarm_search_timeout,
		.alarm_lock_timeout, .alarm_pos_mismatch, .alarm_bad_mode
	);
	tts_post_model u_post (
		.ref_clk, .turret_cw_drive, .turret_ccw_drive, .blind, .clamp_ok,
		.tool_pos(pos_in), .clamp_in_position
	);

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic results;
		$display("counts: compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// One request, then the outcome predicted from mode, tool and turret state
	task automatic run(input logic [3:0] m, input logic [2:0] t, input logic lb);
		int k;
		logic std, nochk, skip, srch, lck;
		std = (m == 4'h1) || (m >= 4'h5 && m <= 4'h8);
		nochk = (m == 4'h2);
		skip = (t == exp_tool) && (nochk || (std && !blind && u_post.pos == t));
		srch = (std || nochk) && !skip && blind;
		lck = (std || nochk) && !skip && !srch && clamp_sense_enable && !clamp_ok;
		@(negedge ref_clk);
		mode = m;
		target_tool = t;
		change_req = 1'b1;
		@(negedge ref_clk);
		change_req = 1'b0;
		// Sensors lost once clamping starts must trip the final check in modes 1 and 5 to 8
		for (k = 0; k < 4000 && change_done !== 1'b1; k++) begin
			if (lb && turret_ccw_drive === 1'b1)
				blind = 1'b1;
			@(negedge ref_clk);
		end
		chk("change_done", change_done, 1);
		chk("busy", busy, 0);
		chk("skipped", change_skipped, skip);
		chk("search alarm", alarm_search_timeout, srch);
		chk("lock alarm", alarm_lock_timeout, lck);
		chk("bad mode", alarm_bad_mode, !(std || nochk || m == 4'h0));
		chk("mismatch", alarm_pos_mismatch, lb && std && !skip && !srch && !lck);
		if (((std || nochk) && !skip && !srch && !lck) || m == 4'h0)
			exp_tool = t;
		chk("tool", current_tool, exp_tool);
		@(negedge ref_clk);
		chk("cw", turret_cw_drive, m == 4'h0 ? general_out_twelve : 1'b0);
		chk("ccw", turret_ccw_drive, m == 4'h0 ? general_out_eleven : 1'b0);
		if (lb)
			blind = 1'b0;
	endtask : run

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Expected run is under 1000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		$display("watchdog expired");
		results();
	end

	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		mode = 4'h1;
		search_lim = 16'h0014;
		t1 = 16'h0002;
		lock_t = 16'h0003;
		t2 = 16'h0002;
		clamp_sense_enable = 1'b0;
		change_req = 1'b0;
		target_tool = 3'h0;
		general_out_eleven = 1'b0;
		general_out_twelve = 1'b0;
		blind = 1'b0;
		clamp_ok = 1'b1;
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		run(4'h1, 3'h2, 1'b0);
		run(4'h1, 3'h2, 1'b0);
		$display("test index and skip done");
		for (int m = 5; m <= 8; m++) begin
			rng = xs(rng);
			{general_out_eleven, general_out_twelve} = rng[4:3];
			run(m[3:0], rng[2:0], 1'b0);
		end
		$display("test mode aliases done");
		blind = 1'b1;
		search_lim = 16'h0005;
		run(4'h2, exp_tool[2:0], 1'b0);
		run(4'h1, exp_tool[2:0], 1'b0);
		blind = 1'b0;
		search_lim = 16'h0014;
		$display("test blind sensors done");
		clamp_sense_enable = 1'b1;
		t1 = 16'h0000;
		rng = xs(rng);
		run(4'h2, rng[2:0] ^ 3'h4, 1'b0);
		clamp_ok = 1'b0;
		run(4'h1, exp_tool[2:0] + 3'h3, 1'b0);
		clamp_ok = 1'b1;
		clamp_sense_enable = 1'b0;
		$display("test clamp sense done");
		run(4'h1, exp_tool[2:0] + 3'h1, 1'b1);
		run(4'h2, exp_tool[2:0] + 3'h1, 1'b1);
		$display("test final check done");
		// A frozen enable must hold off a standing request until the enable rises again
		clk_en = 1'b0;
		mode = 4'h1;
		target_tool = exp_tool[2:0] + 3'h1;
		change_req = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("frozen busy", busy, 0);
		chk("frozen cw", turret_cw_drive, 0);
		clk_en = 1'b1;
		@(negedge ref_clk);
		change_req = 1'b0;
		chk("busy", busy, 1);
		chk("cw", turret_cw_drive, 1);
		srst = 1'b1;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		@(negedge ref_clk);
		chk("reset cw", turret_cw_drive, 0);
		chk("reset busy", busy, 0);
		chk("reset tool", current_tool, 0);
		exp_tool = 0;
		$display("test freeze and reset done");
		for (int m = 0; m < 16; m++) begin
			rng = xs(rng);
			{general_out_eleven, general_out_twelve} = rng[4:3];
			if (m < 1 || (m > 2 && m < 5) || m > 8)
				run(m[3:0], rng[2:0], 1'b0);
		end
		$display("test line-up and bad modes done");
		results();
	end
endmodule : tb_turret_tool_change_sequencer
`default_nettype wire

// >>> tts_post_model.sv
`timescale 1ns/1ps
`default_nettype none
module tts_post_model #(
	parameter int STEP_CYC = 6,
	parameter int CLAMP_CYC = 5
) (
	input wire logic ref_clk,
	input wire logic turret_cw_drive,
	input wire logic turret_ccw_drive,
	input wire logic blind,
	input wire logic clamp_ok,
	output logic [7:0] tool_pos,
	output logic clamp_in_position
);
	int pos = 0;
	int step_cnt = 0;
	int clamp_cnt = 0;
	// Blind mimics a broken sensor harness: no station reads active
	assign tool_pos = blind ? 8'h00 : 8'h01 << pos;
	always @(posedge ref_clk) begin
		if (turret_cw_drive) begin
			step_cnt <= (step_cnt == STEP_CYC - 1) ? 0 : step_cnt + 1;
			if (step_cnt == STEP_CYC - 1) begin
				pos <= (pos + 1) % 8;
			end
		end else begin
			step_cnt <= 0;
		end
		clamp_cnt <= turret_ccw_drive ? clamp_cnt + 1 : 0;
	end
	// Pawl seats only after the motor has pushed back for a while
	assign clamp_in_position = clamp_ok && clamp_cnt >= CLAMP_CYC;
endmodule : tts_post_model
`default_nettype wire

// >>> tts_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) Mode value selects behaviour: 0 line-up, 1 standard with check, 2 no check.
// (R2) Modes 5 to 8 behave exactly like mode 1.
// (R3) Mode 0 runs line-up tool post operation, no turret rotation.
// (R4) Mode 1 skips when same tool and position input agrees, else indexes.
// (R5) Mode 2 skips whenever the tool numbers match, ignoring position inputs.
// (R6) Clockwise drive on until target position input seen, then off.
// (R7) Search time limit exceeded: clockwise off, search timeout alarm.
// (R8) After clockwise release and delay t1, counter-clockwise drive on to clamp.
// (R9) Clamp sense off: hold counter-clockwise for lock time, then continue.
// (R10) Clamp sense on, no clamp input in lock time: release, lock alarm.
// (R11) Clamp sense on, clamp input in time: wait further delay t2.
// (R12) Clamp phase done: counter-clockwise drive released, mechanics finished.
// (R13) Mode 1 compares sensed position with current tool; mismatch alarms.
// (R14) Mode 2 omits the comparison and completes after release.
// (R15) Eight position inputs, clamp input; two drives reusable as general outputs.
// (R16) Delays timed by a counter on a fixed time base, loaded per phase.
module tts_sequencer #(
	parameter int unsigned TICK_CYCLES = tts_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [tts_pkg::MODE_W-1:0] tool_change_mode_select,
	input wire logic [tts_pkg::TIME_W-1:0] index_search_time_limit,
	input wire logic [tts_pkg::TIME_W-1:0] cw_to_ccw_delay,
	input wire logic [tts_pkg::TIME_W-1:0] clamp_lock_time,
	input wire logic [tts_pkg::TIME_W-1:0] post_clamp_delay,
	input wire logic clamp_sense_enable,
	input wire logic change_req,
	input wire logic [2:0] target_tool,
	input wire logic tool_pos_in_1,
	input wire logic tool_pos_in_2,
	input wire logic tool_pos_in_3,
	input wire logic tool_pos_in_4,
	input wire logic tool_pos_in_5,
	input wire logic tool_pos_in_6,
	input wire logic tool_pos_in_7,
	input wire logic tool_pos_in_8,
	input wire logic clamp_in_position,
	input wire logic general_out_eleven,
	input wire logic general_out_twelve,
	output logic turret_cw_drive,
	output logic turret_ccw_drive,
	output logic [2:0] current_tool,
	output logic busy,
	output logic change_done,
	output logic change_skipped,
	output logic alarm_search_timeout,
	output logic alarm_lock_timeout,
	output logic alarm_pos_mismatch,
	output logic alarm_bad_mode
);
	typedef struct packed {
		tts_pkg::tts_state_type st;
		logic [2:0] cur;
		logic [2:0] tgt;
		logic nochk;
		logic cw;
		logic ccw;
		logic busy;
		logic done;
		logic skip;
		logic alm_search;
		logic alm_lock;
		logic alm_conf;
		logic alm_mode;
		logic ld;
		logic [tts_pkg::TIME_W-1:0] ld_val;
	} tts_seq_type;

	tts_seq_type s_r;
	tts_seq_type s_nxt;
	logic [7:0] pos_vec;
	logic pos_hit;
	logic pos_cur;
	logic tmr_expired;
	tts_pkg::tts_kind_type req_kind;

	function automatic tts_pkg::tts_kind_type mode_kind(input logic [3:0] m);
		if (m == tts_pkg::MODE_LINEUP) begin
			return tts_pkg::KIND_LINEUP; // [R3]
		end else if (m == tts_pkg::MODE_STD) begin
			return tts_pkg::KIND_STD;
		end else if (m == tts_pkg::MODE_NOCHK) begin
			return tts_pkg::KIND_NOCHK;
		end else if (m >= tts_pkg::MODE_STD_ALIAS_LO && m <= tts_pkg::MODE_STD_ALIAS_HI) begin
			return tts_pkg::KIND_STD; // [R2]
		end
		return tts_pkg::KIND_BAD;
	endfunction : mode_kind

	assign pos_vec = {tool_pos_in_8, tool_pos_in_7, tool_pos_in_6, tool_pos_in_5,
		tool_pos_in_4, tool_pos_in_3, tool_pos_in_2, tool_pos_in_1}; // [R15]
	assign pos_hit = pos_vec[s_r.tgt];
	// Skip test reads the requested station, before any motion
	assign pos_cur = pos_vec[target_tool];
	assign req_kind = mode_kind(tool_change_mode_select); // [R1]

	tts_interval_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.load(s_r.ld),
		.load_value(s_r.ld_val),
		.expired(tmr_expired)
	); // [R16]

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.ld = 1'b0;
		unique case (s_r.st)
			tts_pkg::ST_IDLE: begin
				s_nxt.busy = 1'b0;
				// Drives are free for general use only on a line-up post
				if (req_kind == tts_pkg::KIND_LINEUP) begin
					s_nxt.cw = general_out_twelve; // [R15]
					s_nxt.ccw = general_out_eleven;
				end else begin
					s_nxt.cw = 1'b0;
					s_nxt.ccw = 1'b0;
				end
				if (change_req) begin
					s_nxt.alm_search = 1'b0;
					s_nxt.alm_lock = 1'b0;
					s_nxt.alm_conf = 1'b0;
					s_nxt.alm_mode = 1'b0;
					s_nxt.skip = 1'b0;
					s_nxt.tgt = target_tool;
					s_nxt.nochk = (req_kind == tts_pkg::KIND_NOCHK);
					unique case (req_kind)
						tts_pkg::KIND_LINEUP: begin
							s_nxt.cur = target_tool; // [R3]
							s_nxt.done = 1'b1;
						end
						tts_pkg::KIND_BAD: begin
							s_nxt.alm_mode = 1'b1;
							s_nxt.done = 1'b1;
						end
						default: begin
							if (target_tool == s_r.cur &&
								(req_kind == tts_pkg::KIND_NOCHK || pos_cur)) begin
								s_nxt.skip = 1'b1; // [R4] [R5]
								s_nxt.done = 1'b1;
							end else begin
								s_nxt.cw = 1'b1; // [R6]
								s_nxt.ccw = 1'b0;
								s_nxt.busy = 1'b1;
								s_nxt.ld = 1'b1;
								s_nxt.ld_val = index_search_time_limit;
								s_nxt.st = tts_pkg::ST_SEARCH;
							end
						end
					endcase
				end
			end
			tts_pkg::ST_SEARCH: begin
				if (pos_hit) begin
					s_nxt.cw = 1'b0; // [R6]
					s_nxt.ld = 1'b1;
					s_nxt.ld_val = cw_to_ccw_delay;
					s_nxt.st = tts_pkg::ST_T1;
				end else if (tmr_expired) begin
					s_nxt.cw = 1'b0; // [R7]
					s_nxt.alm_search = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.st = tts_pkg::ST_IDLE;
				end
			end
			tts_pkg::ST_T1: begin
				if (tmr_expired) begin
					s_nxt.ccw = 1'b1; // [R8]
					s_nxt.ld = 1'b1;
					s_nxt.ld_val = clamp_lock_time;
					s_nxt.st = tts_pkg::ST_LOCK;
				end
			end
			tts_pkg::ST_LOCK: begin
				// Clamp input tested first, so it wins over a coincident expiry
				if (!clamp_sense_enable) begin
					if (tmr_expired) begin
						s_nxt.st = tts_pkg::ST_FINISH; // [R9]
					end
				end else if (clamp_in_position) begin
					s_nxt.ld = 1'b1; // [R11]
					s_nxt.ld_val = post_clamp_delay;
					s_nxt.st = tts_pkg::ST_POST;
				end else if (tmr_expired) begin
					s_nxt.ccw = 1'b0; // [R10]
					s_nxt.alm_lock = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.st = tts_pkg::ST_IDLE;
				end
			end
			tts_pkg::ST_POST: begin
				if (tmr_expired) begin
					s_nxt.st = tts_pkg::ST_FINISH; // [R11]
				end
			end
			tts_pkg::ST_FINISH: begin
				// Tool number follows the target even when the final check alarms
				s_nxt.ccw = 1'b0; // [R12]
				s_nxt.cur = s_r.tgt;
				s_nxt.alm_conf = !s_r.nochk && !pos_hit; // [R13] [R14]
				s_nxt.done = 1'b1;
				s_nxt.busy = 1'b0;
				s_nxt.st = tts_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = tts_pkg::ST_IDLE;
			end
		endcase
	end

	// Reset ignores the enable, so a frozen block can still be cleared
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '{st: tts_pkg::ST_IDLE, cur: tts_pkg::TOOL_RESET, tgt: tts_pkg::TOOL_RESET,
				ld_val: '0, default: 1'b0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign turret_cw_drive = s_r.cw;
	assign turret_ccw_drive = s_r.ccw;
	assign current_tool = s_r.cur;
	assign busy = s_r.busy;
	assign change_done = s_r.done;
	assign change_skipped = s_r.skip;
	assign alarm_search_timeout = s_r.alm_search;
	assign alarm_lock_timeout = s_r.alm_lock;
	assign alarm_pos_mismatch = s_r.alm_conf;
	assign alarm_bad_mode = s_r.alm_mode;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	sequence req_turret;
		s_r.st == tts_pkg::ST_IDLE && clk_en && change_req &&
			(req_kind == tts_pkg::KIND_STD || req_kind == tts_pkg::KIND_NOCHK);
	endsequence
	sequence finish_step;
		s_r.st == tts_pkg::ST_FINISH && clk_en;
	endsequence

	a_mode1_start: assert property (req_turret and // [R4]
		(req_kind == tts_pkg::KIND_STD && (target_tool != s_r.cur || !pos_cur))
		|=> turret_cw_drive && busy)
		else $error("indexing did not start");
	a_mode2_skip: assert property (req_turret and // [R5]
		(req_kind == tts_pkg::KIND_NOCHK && target_tool == s_r.cur)
		|=> change_skipped && change_done && !turret_cw_drive)
		else $error("mode 2 did not skip");
	a_lineup_mode: assert property (s_r.st == tts_pkg::ST_IDLE && // [R3]
		clk_en && change_req && tool_change_mode_select == tts_pkg::MODE_LINEUP
		|=> change_done && current_tool == $past(target_tool) && !busy)
		else $error("line-up change wrong");
	a_search_release: assert property (s_r.st == tts_pkg::ST_SEARCH && // [R6]
		clk_en && pos_hit |=> !turret_cw_drive && !turret_ccw_drive)
		else $error("cw not released on target");
	a_search_timeout: assert property (s_r.st == tts_pkg::ST_SEARCH && // [R7]
		clk_en && !pos_hit && tmr_expired
		|=> !turret_cw_drive && alarm_search_timeout && change_done)
		else $error("search timeout mishandled");
	a_ccw_after_t1: assert property (s_r.st == tts_pkg::ST_T1 && clk_en && // [R8]
		tmr_expired |=> turret_ccw_drive && !turret_cw_drive)
		else $error("ccw not raised after t1");
	a_lock_nosense: assert property (s_r.st == tts_pkg::ST_LOCK && clk_en && // [R9]
		!clamp_sense_enable && tmr_expired |=> finish_step or
		(s_r.st == tts_pkg::ST_FINISH && turret_ccw_drive))
		else $error("lock time not honoured");
	a_lock_timeout: assert property (s_r.st == tts_pkg::ST_LOCK && clk_en && // [R10]
		clamp_sense_enable && !clamp_in_position && tmr_expired
		|=> !turret_ccw_drive && alarm_lock_timeout)
		else $error("lock timeout mishandled");
	a_post_clamp: assert property (s_r.st == tts_pkg::ST_LOCK && clk_en && // [R11]
		clamp_sense_enable && clamp_in_position
		|=> s_r.st == tts_pkg::ST_POST && turret_ccw_drive)
		else $error("t2 wait not entered");
	a_finish_release: assert property (finish_step // [R12]
		|=> !turret_ccw_drive && change_done && current_tool == $past(s_r.tgt))
		else $error("ccw not released at end");
	a_confirm_check: assert property (finish_step ##0 !s_r.nochk // [R13]
		|=> alarm_pos_mismatch == !$past(pos_hit))
		else $error("final check wrong");
	a_nochk_skip: assert property (finish_step ##0 s_r.nochk |=> !alarm_pos_mismatch) // [R14]
		else $error("mode 2 compared positions");
	a_drive_exclusive: assert property (busy |-> !(turret_cw_drive && turret_ccw_drive)) // [R15]
		else $error("both drives on");
	a_timer_loaded: assert property (s_r.st == tts_pkg::ST_IDLE && clk_en && s_nxt.ld // [R16]
		|=> s_r.ld && s_r.ld_val == $past(index_search_time_limit) && !tmr_expired)
		else $error("search timer not loaded");
	// A low enable must leave every register of the sequencer untouched
	a_freeze_hold: assert property (!clk_en // [R16]
		|=> $stable(s_r))
		else $error("state moved while frozen");
endmodule : tts_sequencer
`default_nettype wire

// >>> tts_timer.sv
package tts_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned TICK_TIME_US = 1000;
	localparam int unsigned TICK_CYCLES = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int unsigned PRE_W = 18;
	localparam int unsigned TIME_W = 16;
	localparam int unsigned MODE_W = 4;
	localparam logic [3:0] MODE_LINEUP = 4'h0;
	localparam logic [3:0] MODE_STD = 4'h1;
	localparam logic [3:0] MODE_NOCHK = 4'h2;
	localparam logic [3:0] MODE_STD_ALIAS_LO = 4'h5;
	localparam logic [3:0] MODE_STD_ALIAS_HI = 4'h8;
	localparam logic [2:0] TOOL_RESET = 3'h0;
	typedef enum logic [1:0] {KIND_LINEUP, KIND_STD, KIND_NOCHK, KIND_BAD} tts_kind_type;
	typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_T1, ST_LOCK, ST_POST, ST_FINISH} tts_state_type;
endpackage : tts_pkg

`timescale 1ns/1ps
`default_nettype none
module tts_interval_timer #(
	parameter int unsigned TICK_CYCLES = tts_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [tts_pkg::TIME_W-1:0] load_value,
	output logic expired
);
	typedef struct packed {
		logic [tts_pkg::PRE_W-1:0] pre;
		logic [tts_pkg::TIME_W-1:0] cnt;
	} tts_tmr_type;

	tts_tmr_type s_r;
	tts_tmr_type s_nxt;

	// Count is in time-base units; prescaler restarts on every load
	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.pre = '0;
			s_nxt.cnt = load_value;
		end else if (s_r.cnt != '0) begin
			if (s_r.pre == tts_pkg::PRE_W'(TICK_CYCLES - 1)) begin
				s_nxt.pre = '0;
				s_nxt.cnt = s_r.cnt - 16'h0001;
			end else begin
				s_nxt.pre = s_r.pre + 18'h00001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign expired = (s_r.cnt == '0) && !load;
endmodule : tts_interval_timer
`default_nettype wire
